// File: hdl/pom_pkg.sv
// Package for the pin 6 output source mux: register map, field layout and codes
package pom_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] POM_OFS_CTRL   = 12'h016;
	// Byte address of a one-word register is four times its index
	localparam logic [11:0] POM_ADDR_CTRL  = {POM_OFS_CTRL[9:0], 2'b00};
	localparam logic [11:0] POM_ADDR_STAT  = 12'h05C;
	localparam logic [11:0] POM_ADDR_RXEN  = 12'h060;
	localparam logic [7:0]  POM_CTRL_RESET = 8'h00;
	localparam logic [3:0]  POM_RXEN_RESET = 4'hF;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int POM_SEL_LSB = 5;
	localparam int POM_SRC_LSB = 2;
	localparam int POM_VAL_BIT = 1;
	localparam int POM_EN_BIT  = 0;

	localparam int POM_NRX = 4;
	localparam int POM_NTX = 2;

	// ****************************************
	// Source and signal codes
	// ****************************************
	localparam logic [2:0] POM_SRC_STATUS = 3'h4;
	localparam logic [2:0] POM_SRC_RSVD   = 3'h5;
	localparam logic [2:0] POM_SRC_TX0    = 3'h6;

	localparam logic [2:0] POM_SEL_0 = 3'h0;
	localparam logic [2:0] POM_SEL_1 = 3'h1;
	localparam logic [2:0] POM_SEL_2 = 3'h2;
	localparam logic [2:0] POM_SEL_3 = 3'h3;
	localparam logic [2:0] POM_SEL_4 = 3'h4;
	localparam logic [2:0] POM_SEL_5 = 3'h5;
	localparam logic [2:0] POM_SEL_6 = 3'h6;
	localparam logic [2:0] POM_SEL_7 = 3'h7;

	typedef enum logic [1:0] {POM_CLS_RX, POM_CLS_STATUS, POM_CLS_TX, POM_CLS_NONE} pom_class_e;

	// Status of one receive port
	typedef struct packed {
		logic [3:0] remote_pin;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
	} pom_rx_s;

	// Status of one CSI-2 transmit port
	typedef struct packed {
		logic [3:0] rx_select;
		logic       frame_valid;
		logic       line_valid;
		logic       synced;
		logic       irq;
	} pom_tx_s;

	// Control register fields
	typedef struct packed {
		logic [2:0] pin6_signal_select;
		logic [2:0] pin6_source_select;
		logic       pin6_local_value;
		logic       pin6_drive_enable;
	} pom_ctrl_s;

endpackage

// File: hdl/pom_apb_regs.sv
// APB slave holding the pin control and receive-enable registers
`timescale 1ns/100ps
module pom_apb_regs
	import pom_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [7:0]          stat_in,
	output pom_pkg::pom_ctrl_s       ctrl,
	output logic [pom_pkg::POM_NRX-1:0] rx_enable
);
	import pom_pkg::*;

	logic [7:0]  ctrl_q, ctrl_d;
	logic [3:0]  rxen_q, rxen_d;
	logic [31:0] prdata_q, prdata_d;
	logic        access;
	logic        hit;

	assign access = psel && penable;
	assign hit = (paddr == POM_ADDR_CTRL) || (paddr == POM_ADDR_STAT) || (paddr == POM_ADDR_RXEN);
	assign pready = 1'b1;
	assign pslverr = access && !hit;

	always_comb begin
		ctrl_d = ctrl_q;
		rxen_d = rxen_q;
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				POM_ADDR_CTRL: prdata_d = {24'h000000, ctrl_q};
				POM_ADDR_STAT: prdata_d = {24'h000000, stat_in};
				POM_ADDR_RXEN: prdata_d = {28'h0000000, rxen_q};
				default:       prdata_d = 32'h00000000;
			endcase
		end
		if (access && pwrite && pstrb[0]) begin
			if (paddr == POM_ADDR_CTRL)
				ctrl_d = pwdata[7:0]; // see [R1]
			if (paddr == POM_ADDR_RXEN)
				rxen_d = pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= POM_CTRL_RESET; // see [R1]
			rxen_q   <= POM_RXEN_RESET;
			prdata_q <= 32'h00000000;
		end else begin
			ctrl_q   <= ctrl_d;
			rxen_q   <= rxen_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign ctrl = pom_ctrl_s'(ctrl_q);
	assign rx_enable = rxen_q;

	property p_write_lands;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && pstrb[0] && paddr == POM_ADDR_CTRL |=> ctrl_q == $past(pwdata[7:0]);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("control write not stored"); // see [R1]
endmodule

// File: hdl/pom_pin_select.sv
// Combinational selection of the pin level from source and signal codes
`timescale 1ns/100ps
module pom_pin_select
	import pom_pkg::*;
(
	input  pom_pkg::pom_ctrl_s                  ctrl,
	input  pom_pkg::pom_rx_s [pom_pkg::POM_NRX-1:0] rx,
	input  pom_pkg::pom_tx_s [pom_pkg::POM_NTX-1:0] tx,
	input  wire logic [pom_pkg::POM_NRX-1:0]    rx_enable,
	input  wire logic                           camera_sync_pulse,
	output logic                                level,
	output pom_pkg::pom_class_e                 cls
);
	import pom_pkg::*;

	// Reduce a set of bits over a mask; empty mask gives 0
	function automatic logic masked_and(input logic [3:0] v, input logic [3:0] m);
		masked_and = (m != 4'h0) && ((v | ~m) == 4'hF);
	endfunction

	function automatic logic masked_or(input logic [3:0] v, input logic [3:0] m);
		masked_or = |(v & m);
	endfunction

	logic [3:0] lock_v, pass_v;
	pom_rx_s    r;
	pom_tx_s    t;

	always_comb begin
		for (int i = 0; i < POM_NRX; i++) begin
			lock_v[i] = rx[i].lock;
			pass_v[i] = rx[i].pass;
		end
	end

	always_comb begin
		r = rx[ctrl.pin6_source_select[1:0]];
		t = tx[ctrl.pin6_source_select[0]];
		level = 1'b0;
		cls = POM_CLS_NONE;
		if (!ctrl.pin6_source_select[2]) begin
			cls = POM_CLS_RX; // see [R2]
			case (ctrl.pin6_signal_select)
				POM_SEL_0: level = r.remote_pin[0]; // see [R3]
				POM_SEL_1: level = r.remote_pin[1]; // see [R11]
				POM_SEL_2: level = r.remote_pin[2]; // see [R3]
				POM_SEL_3: level = r.remote_pin[3]; // see [R3]
				POM_SEL_4: level = r.lock; // see [R4]
				POM_SEL_5: level = r.pass; // see [R4]
				POM_SEL_6: level = r.frame_valid; // see [R4]
				POM_SEL_7: level = r.line_valid; // see [R4]
				default:   level = 1'b0;
			endcase
		end else if (ctrl.pin6_source_select == POM_SRC_STATUS) begin
			cls = POM_CLS_STATUS;
			case (ctrl.pin6_signal_select)
				POM_SEL_0: level = ctrl.pin6_local_value; // see [R5] [R10]
				POM_SEL_1: level = masked_or(lock_v, rx_enable); // see [R6]
				POM_SEL_2: level = masked_and(lock_v, rx_enable); // see [R6]
				POM_SEL_3: level = masked_and(pass_v, rx_enable); // see [R6]
				POM_SEL_4: level = camera_sync_pulse; // see [R12]
				default:   level = 1'b0;
			endcase
		end else if (ctrl.pin6_source_select != POM_SRC_RSVD) begin
			cls = POM_CLS_TX; // see [R2]
			case (ctrl.pin6_signal_select)
				POM_SEL_0: level = masked_and(pass_v, t.rx_select); // see [R7]
				POM_SEL_1: level = masked_or(pass_v, t.rx_select); // see [R7]
				POM_SEL_2: level = t.frame_valid; // see [R8]
				POM_SEL_3: level = t.line_valid; // see [R8]
				POM_SEL_4: level = t.synced; // see [R9]
				POM_SEL_5: level = t.irq; // see [R9]
				default:   level = 1'b0;
			endcase
		end
	end
endmodule

// File: hdl/pom_pin6_output_mux.sv
// Top of the pin 6 output source mux: APB registers, selection and pin driver
// What this block does
// [R1] Control register at offset 0x16, reset to all zeros.
// [R2] Bits 4:2 pick source: rx ports 0-3, status, tx ports 0-1; 101 reserved.
// [R3] Rx source: codes 000, 010, 011 drive remote pins 0, 2, 3.
// [R4] Rx source: codes 100-111 drive lock, pass, frame valid, line valid.
// [R5] Status source: code 000 drives the register's local value bit.
// [R6] Status: 001 OR of locks, 010 AND of locks, 011 AND of passes, enabled ports.
// [R7] Tx source: 000 AND, 001 OR of pass over its selected rx ports.
// [R8] Tx source: 010 frame valid, 011 line valid of that tx port.
// [R9] Tx source: 100 synchronized flag, 101 tx interrupt, 110-111 reserved.
// [R10] Bit 1 is the local level; bit 0 enables the pin driver.
// [R11] Rx source: code 001 drives remote pin 1.
// [R12] Status: code 100 drives camera sync pulse; 101-111 reserved.
`timescale 1ns/100ps
module pom_pin6_output_mux
	import pom_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  pom_pkg::pom_rx_s [pom_pkg::POM_NRX-1:0] rx_status,
	input  pom_pkg::pom_tx_s [pom_pkg::POM_NTX-1:0] tx_status,
	input  wire logic                          camera_sync_pulse,
	input  wire logic                          pin6_in,
	output logic                               pin6_out,
	output logic                               pin6_oe
);
	import pom_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	pom_ctrl_s  ctrl;
	logic [3:0] rx_enable;
	logic [7:0] stat;
	logic       level;
	pom_class_e cls;
	logic       out_q, out_d;
	logic       oe_q, oe_d;

	assign stat = {4'h0, pin6_in, out_q, oe_q, (cls == POM_CLS_NONE)};

	pom_apb_regs u_regs (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.stat_in   (stat),
		.ctrl      (ctrl),
		.rx_enable (rx_enable)
	);

	// ****************************************
	// Source selection
	// ****************************************
	pom_pin_select u_sel (
		.ctrl              (ctrl),
		.rx                (rx_status),
		.tx                (tx_status),
		.rx_enable         (rx_enable),
		.camera_sync_pulse (camera_sync_pulse),
		.level             (level),
		.cls               (cls)
	);

	// ****************************************
	// Pin driver
	// ****************************************
	always_comb begin
		out_d = level;
		oe_d = ctrl.pin6_drive_enable; // see [R10]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q  <= oe_d;
		end
	end

	assign pin6_out = out_q;
	assign pin6_oe = oe_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_reset_idle;
		@(posedge pclk) $rose(presetn) |-> !pin6_oe && !pin6_out;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset"); // see [R1]

	property p_src_class;
		@(posedge pclk) disable iff (!presetn)
		(ctrl.pin6_source_select == POM_SRC_RSVD) == (cls == POM_CLS_NONE);
	endproperty
	a_src_class: assert property (p_src_class) else $error("reserved source misclassified"); // see [R2]

	property p_rx_pin;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_RX && ctrl.pin6_signal_select < POM_SEL_4
		|=> pin6_out == $past(rx_status[ctrl.pin6_source_select[1:0]].remote_pin[ctrl.pin6_signal_select[1:0]]);
	endproperty
	a_rx_pin: assert property (p_rx_pin) else $error("remote pin not routed"); // see [R3]

	property p_rx_lock;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_RX && ctrl.pin6_signal_select == POM_SEL_4
		|=> pin6_out == $past(rx_status[ctrl.pin6_source_select[1:0]].lock);
	endproperty
	a_rx_lock: assert property (p_rx_lock) else $error("lock not routed"); // see [R4]

	property p_local;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_STATUS && ctrl.pin6_signal_select == POM_SEL_0
		|=> pin6_out == $past(ctrl.pin6_local_value);
	endproperty
	a_local: assert property (p_local) else $error("local value not driven"); // see [R5]

	property p_or_lock;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_STATUS && ctrl.pin6_signal_select == POM_SEL_1 && rx_enable == 4'h0 |=> !pin6_out;
	endproperty
	a_or_lock: assert property (p_or_lock) else $error("OR of no ports not low"); // see [R6]

	property p_tx_irq;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_TX && ctrl.pin6_signal_select == POM_SEL_5
		|=> pin6_out == $past(tx_status[ctrl.pin6_source_select[0]].irq);
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt not routed"); // see [R9]

	property p_tx_frame;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_TX && ctrl.pin6_signal_select == POM_SEL_2
		|=> pin6_out == $past(tx_status[ctrl.pin6_source_select[0]].frame_valid);
	endproperty
	a_tx_frame: assert property (p_tx_frame) else $error("tx frame valid not routed"); // see [R8]

	property p_enable;
		@(posedge pclk) disable iff (!presetn)
		##1 pin6_oe == $past(ctrl.pin6_drive_enable);
	endproperty
	a_enable: assert property (p_enable) else $error("driver enable mismatch"); // see [R10]

	property p_sync;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_STATUS && ctrl.pin6_signal_select == POM_SEL_4 |=> pin6_out == $past(camera_sync_pulse);
	endproperty
	a_sync: assert property (p_sync) else $error("sync pulse not routed"); // see [R12]

	property p_rsvd_low;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_NONE |=> !pin6_out;
	endproperty
	a_rsvd_low: assert property (p_rsvd_low) else $error("reserved source not low"); // see [R2]

	property p_status_rsvd;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_STATUS && ctrl.pin6_signal_select > POM_SEL_4 |=> !pin6_out;
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status select not low"); // see [R12]

	property p_tx_rsvd;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_TX && ctrl.pin6_signal_select == POM_SEL_7 |=> !pin6_out;
	endproperty
	a_tx_rsvd: assert property (p_tx_rsvd) else $error("reserved tx select not low"); // see [R9]

	property p_tx_and_empty;
		@(posedge pclk) disable iff (!presetn)
		cls == POM_CLS_TX && ctrl.pin6_signal_select == POM_SEL_0
		&& tx_status[ctrl.pin6_source_select[0]].rx_select == 4'h0 |=> !pin6_out;
	endproperty
	a_tx_and_empty: assert property (p_tx_and_empty) else $error("AND over no ports not low"); // see [R7]

	c_rx:  cover property (@(posedge pclk) disable iff (!presetn) cls == POM_CLS_RX && pin6_oe);
	c_st:  cover property (@(posedge pclk) disable iff (!presetn) cls == POM_CLS_STATUS && pin6_out);
	c_tx:  cover property (@(posedge pclk) disable iff (!presetn) cls == POM_CLS_TX && pin6_out);
	c_rsv: cover property (@(posedge pclk) disable iff (!presetn) cls == POM_CLS_NONE && pin6_oe);
endmodule

// File: dv/pom_pin_sampler.sv
// Partner model: external logic that sees the pin and feeds its level back
`timescale 1ns/100ps
module pom_pin_sampler (
	input  wire logic pclk,
	input  wire logic pin6_out,
	input  wire logic pin6_oe,
	output logic      pin6_in
);
	logic last_q = 1'b0;

	always_ff @(posedge pclk) begin
		last_q <= pin6_oe ? pin6_out : last_q;
	end

	// Undriven wire has no pull: show the inverse of the last driven level, never a stale copy
	assign pin6_in = pin6_oe ? pin6_out : ~last_q;
endmodule

// File: dv/pin6_output_source_mux_tb.sv
// Testbench for the pin 6 output source mux
`timescale 1ns/100ps
module pin6_output_source_mux_tb;
	import pom_pkg::*;
	logic                    pclk              = 1'b0;
	logic                    presetn           = 1'b0;
	logic                    psel              = 1'b0;
	logic                    penable           = 1'b0;
	logic                    pwrite            = 1'b0;
	logic                    camera_sync_pulse = 1'b0;
	logic [11:0]             paddr             = 12'h000;
	logic [31:0]             pwdata            = 32'h0;
	logic [3:0]              pstrb             = 4'hF;
	pom_rx_s [POM_NRX-1:0]   rx_v              = '0;
	pom_tx_s [POM_NTX-1:0]   tx_v              = '0;
	logic [31:0]             prdata;
	logic [31:0]             rd;
	logic                    pready;
	logic                    pslverr;
	logic                    err;
	logic                    e;
	logic                    pin6_in;
	logic                    pin6_out;
	logic                    pin6_oe;
	logic [7:0]              c;
	logic [3:0]              en_m;
	logic [31:0]             pats [4] = '{32'hFFFFFFFF, 32'h0, 32'hA55A3CC3, 32'h5AA5C33C};
	int                      miscompares = 0;
	int                      n_compared  = 0;

	always #10 pclk = ~pclk;

	pom_pin6_output_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_status(rx_v), .tx_status(tx_v), .camera_sync_pulse(camera_sync_pulse), .pin6_in(pin6_in),
		.pin6_out(pin6_out), .pin6_oe(pin6_oe));

	pom_pin_sampler u_far (.pclk(pclk), .pin6_out(pin6_out), .pin6_oe(pin6_oe), .pin6_in(pin6_in));

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Expected pin level worked out from source, select and inputs
	function automatic logic exp_pin(logic [7:0] c, pom_rx_s [3:0] r, pom_tx_s [1:0] t, logic [3:0] m, logic s);
		logic [2:0] src;
		logic [2:0] sel;
		logic [3:0] lk;
		logic [3:0] ps;
		pom_rx_s    x;
		pom_tx_s    y;
		src = c[4:2];
		sel = c[7:5];
		x = r[src[1:0]];
		y = t[src[0]];
		for (int i = 0; i < 4; i++) begin
			lk[i] = r[i].lock;
			ps[i] = r[i].pass;
		end
		if (!src[2]) begin
			case (sel)
				3'h4: return x.lock;
				3'h5: return x.pass;
				3'h6: return x.frame_valid;
				3'h7: return x.line_valid;
				default: return x.remote_pin[sel[1:0]];
			endcase
		end
		if (src == 3'h5)
			return 1'b0;
		if (src == 3'h4) begin
			case (sel)
				3'h0: return c[1];
				3'h1: return |(lk & m);
				3'h2: return m != 4'h0 && &(lk | ~m);
				3'h3: return m != 4'h0 && &(ps | ~m);
				3'h4: return s;
				default: return 1'b0;
			endcase
		end
		case (sel)
			3'h0: return y.rx_select != 4'h0 && &(ps | ~y.rx_select);
			3'h1: return |(ps & y.rx_select);
			3'h2: return y.frame_valid;
			3'h3: return y.line_valid;
			3'h4: return y.synced;
			3'h5: return y.irq;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(pin6_oe, 0);
		apb(0, POM_ADDR_CTRL, 0);
		chk(rd, {24'h0, POM_CTRL_RESET});
		apb(0, POM_ADDR_RXEN, 0);
		chk(rd, {28'h0, POM_RXEN_RESET});
		apb(0, 12'h0FC, 0);
		chk(err, 1);
		chk(rd, 0);
		for (int m = 0; m < 3; m++) begin
			en_m = (m == 0) ? 4'hF : (m == 1) ? 4'h5 : 4'h0;
			apb(1, POM_ADDR_RXEN, {28'h0, en_m});
			for (int s = 0; s < 8; s++) begin
				for (int l = 0; l < 8; l++) begin
					for (int k = 0; k < 4; k++) begin
						c = {l[2:0], s[2:0], k[0], k != 3};
						apb(1, POM_ADDR_CTRL, {24'h0, c});
						rx_v              <= pats[k];
						tx_v              <= pats[k][31:16];
						camera_sync_pulse <= k[1];
						repeat (2) @(negedge pclk);
						e = exp_pin(c, pats[k], pats[k][31:16], en_m, k[1]);
						chk(pin6_oe, c[0]);
						if (c[0])
							chk(pin6_out, e);
						apb(0, POM_ADDR_CTRL, 0);
						chk(rd, {24'h0, c});
						apb(0, POM_ADDR_STAT, 0);
						chk(rd & ~{28'h0, !c[0], 3'h0}, {28'h0, c[0] & e, e, c[0], s == 5});
					end
				end
			end
		end
		pstrb <= 4'h0;
		apb(1, POM_ADDR_CTRL, 32'h000000AA);
		pstrb <= 4'hF;
		apb(0, POM_ADDR_CTRL, 0);
		chk(rd, {24'h0, c});
		apb(1, 12'h0FC, 32'hFF);
		apb(0, POM_ADDR_CTRL, 0);
		chk(rd, {24'h0, c});
		apb(1, POM_ADDR_CTRL, 32'h00000003);
		repeat (2) @(negedge pclk);
		chk(pin6_oe, 1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(pin6_oe, 0);
		chk(pin6_out, 0);
		apb(0, POM_ADDR_CTRL, 0);
		chk(rd, {24'h0, POM_CTRL_RESET});
		print_verdict;
	end

	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		print_verdict;
	end
endmodule
